// ---- hw/efm_event_flags.sv ----
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RL1] Pending bit 9 mac transmit, app-protected
// [RL2] Pending bit 8 mac timer, app-protected
// [RL3] Pending bit 4 sleep timer, app-protected
// [RL4] Pending bit 2 debug link, app-protected
// [RL5] Miss bit 10 mac receive, app-protected
// [RL6] Miss bit 9 mac transmit, app-protected
// [RL7] Miss bit 8 mac timer, app-protected
// [RL8] Miss bit 7 security, app-protected
// [RL9] Miss bit 4 sleep timer, app-protected
// [RL10] Miss bit 3 baseband, app-protected
// [RL11] Miss bit 2 debug link, app-protected
// [RL12] Miss bit 1 software, app-protected
// [RL13] Any trigger write raises software event
// [RL14] Software clears flags by writing ones
// [RL15] Repeat while pending sets miss flag
// [RL16] One-cycle event pulses set flags synchronously
// [RL17] Event beats coincident acknowledge
// [RL18] Bit zero reads zero; flags reset zero
// [RL19] Application mode gates system-bit writes
module efm_event_flags #(
   parameter int unsigned FLAG_W = efm_pkg::REG_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [efm_pkg::ADDR_W-1:0] paddr,
   input wire logic [efm_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [efm_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event sources and configuration
   input wire logic [FLAG_W-1:0] event_pulse,
   input wire logic [FLAG_W-1:0] event_enable,
   input wire logic app_mode,
   // Flag outputs
   output logic [FLAG_W-1:0] pending_flags,
   output logic [FLAG_W-1:0] miss_flags,
   output logic software_event_pulse,
   // Interrupt
   output logic irq
);
   // Released reset
   logic rst_sync_n;

   // Bus decode
   logic setup_phase;
   logic access_phase;
   logic [efm_pkg::ADDR_W-1:0] word_idx;
   logic addr_aligned;
   logic hit_pending;
   logic hit_miss;
   logic hit_swtrig;
   logic hit_irq_status;
   logic hit_irq_mask;
   logic hit_any;
   logic wr_access;
   logic rd_access;
   logic [FLAG_W-1:0] wdata_lanes;

   // Flag banks
   logic [FLAG_W-1:0] pend_set;
   logic [FLAG_W-1:0] pend_clear;
   logic [FLAG_W-1:0] miss_set;
   logic [FLAG_W-1:0] miss_clear;
   logic [FLAG_W-1:0] write_allow;
   logic [FLAG_W-1:0] events_in;

   // Software trigger
   logic [FLAG_W-1:0] swtrig_reg;
   logic [FLAG_W-1:0] swtrig_next;
   logic sw_pulse_reg;
   logic sw_pulse_next;

   // Interrupt status and mask
   logic [efm_pkg::IRQ_W-1:0] irq_status_reg;
   logic [efm_pkg::IRQ_W-1:0] irq_status_next;
   logic [efm_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [efm_pkg::IRQ_W-1:0] irq_mask_next;
   logic [efm_pkg::IRQ_W-1:0] irq_events;

   // Read data
   logic [efm_pkg::DATA_W-1:0] prdata_reg;
   logic [efm_pkg::DATA_W-1:0] prdata_next;
   logic [efm_pkg::DATA_W-1:0] rd_mux;

   // Reset release
   efm_reset_sync u_reset_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   // Phase and address decode
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign word_idx = paddr >> efm_pkg::IDX_SHIFT;
   assign addr_aligned = (paddr[1:0] == 2'h0);
   assign hit_pending = addr_aligned & (word_idx == efm_pkg::IDX_PENDING);
   assign hit_miss = addr_aligned & (word_idx == efm_pkg::IDX_MISS);
   assign hit_swtrig = addr_aligned & (word_idx == efm_pkg::IDX_SWTRIG);
   assign hit_irq_status = addr_aligned & (word_idx == efm_pkg::IDX_IRQ_STATUS);
   assign hit_irq_mask = addr_aligned & (word_idx == efm_pkg::IDX_IRQ_MASK);
   assign hit_any = hit_pending | hit_miss | hit_swtrig | hit_irq_status | hit_irq_mask;

   // Writes and reads take effect only at the access edge
   assign wr_access = access_phase & pwrite & hit_any;
   assign rd_access = access_phase & ~pwrite & hit_any;

   // Zero wait states: read data is prepared during the setup cycle
   assign pready = access_phase;
   // Unmapped or misaligned addresses complete with an error and no effect
   assign pslverr = access_phase & ~hit_any;

   // Byte lanes: a lane whose strobe is low writes zeros, harmless for W1C bits
   always_comb begin
      wdata_lanes = '0;
      wdata_lanes[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
      wdata_lanes[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
   end

   // Writable flag bits: application mode loses the system-source bits
   always_comb begin
      write_allow = efm_pkg::IMPL_MASK;
      // [RL19] application mode gating
      if (app_mode) begin
         write_allow = efm_pkg::IMPL_MASK & ~efm_pkg::SYS_MASK;
      end
   end

   // Sources, with the software trigger merged into its own bit
   always_comb begin
      // [RL16] synchronous pulse capture
      events_in = event_pulse & efm_pkg::IMPL_MASK;
      // [RL13] trigger feeds software bit
      events_in[efm_pkg::BIT_SOFTWARE] = event_pulse[efm_pkg::BIT_SOFTWARE] | sw_pulse_reg;
   end

   // Pending bank: set by events, cleared by write-one in allowed bits
   always_comb begin
      pend_set = events_in;
      pend_clear = '0;
      // [RL14] write-one acknowledge
      if (wr_access && hit_pending) begin
         // [RL1] [RL2] [RL3] [RL4] protected system bits
         pend_clear = wdata_lanes & write_allow;
      end
   end

   // Miss bank: an enabled repeat while still pending is recorded, not queued
   always_comb begin
      // [RL15] repeat before acknowledge
      miss_set = events_in & event_enable & pending_flags;
      miss_clear = '0;
      if (wr_access && hit_miss) begin
         // [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] [RL11] [RL12] protected misses
         miss_clear = wdata_lanes & write_allow;
      end
   end

   // [RL17] set beats clear
   efm_flag_bank #(
      .WIDTH(FLAG_W),
      .IMPL(efm_pkg::IMPL_MASK),
      .RESET_VAL(efm_pkg::RST_FLAGS)
   ) u_pending (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .set_bits(pend_set),
      .clear_bits(pend_clear),
      .flags(pending_flags)
   );

   // [RL18] bit zero and reset value
   efm_flag_bank #(
      .WIDTH(FLAG_W),
      .IMPL(efm_pkg::IMPL_MASK),
      .RESET_VAL(efm_pkg::RST_FLAGS)
   ) u_miss (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .set_bits(miss_set),
      .clear_bits(miss_clear),
      .flags(miss_flags)
   );

   // Software trigger: value kept for readback, any write fires one pulse
   always_comb begin
      swtrig_next = swtrig_reg;
      sw_pulse_next = 1'b0;
      // [RL13] any write triggers
      if (wr_access && hit_swtrig) begin
         if (pstrb[0]) begin
            swtrig_next[7:0] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            swtrig_next[15:8] = pwdata[15:8];
         end
         sw_pulse_next = 1'b1;
      end
   end

   // Trigger storage; the pulse lands in the flag one cycle after the write
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         swtrig_reg <= efm_pkg::RST_SWTRIG;
         sw_pulse_reg <= 1'b0;
      end else begin
         swtrig_reg <= swtrig_next;
         sw_pulse_reg <= sw_pulse_next;
      end
   end

   assign software_event_pulse = sw_pulse_reg;

   // Block events for the own interrupt: any new pending set, any new miss
   always_comb begin
      irq_events = '0;
      irq_events[efm_pkg::IRQ_BIT_PENDING] = |(pend_set & ~pending_flags);
      irq_events[efm_pkg::IRQ_BIT_MISS] = |miss_set;
   end

   // Status clears on read, mask is plain read/write; a same-cycle event survives
   always_comb begin
      irq_status_next = irq_status_reg;
      irq_mask_next = irq_mask_reg;
      if (rd_access && hit_irq_status) begin
         irq_status_next = '0;
      end
      irq_status_next = irq_status_next | irq_events;
      if (wr_access && hit_irq_mask && pstrb[0]) begin
         irq_mask_next = pwdata[efm_pkg::IRQ_W-1:0];
      end
   end

   // Interrupt state
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_status_reg <= efm_pkg::RST_IRQ;
         irq_mask_reg <= efm_pkg::RST_IRQ;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign irq = |(irq_status_reg & irq_mask_reg);

   // Read selection; unused upper bits read zero
   always_comb begin
      rd_mux = '0;
      if (hit_pending) begin
         rd_mux[FLAG_W-1:0] = pending_flags;
      end else if (hit_miss) begin
         rd_mux[FLAG_W-1:0] = miss_flags;
      end else if (hit_swtrig) begin
         rd_mux[FLAG_W-1:0] = swtrig_reg;
      end else if (hit_irq_status) begin
         rd_mux[efm_pkg::IRQ_W-1:0] = irq_status_reg;
      end else if (hit_irq_mask) begin
         rd_mux[efm_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
   end

   // Sample read data in the setup cycle; holding it keeps prdata from a flop
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_phase && !pwrite) begin
         prdata_next = rd_mux;
      end
   end

   // Read data register
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prdata_reg <= '0;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
endmodule
`default_nettype wire

// ---- shared/efm_pkg.sv ----
// Shared constants for the event flag and miss block
package efm_pkg;
   // Register word width and bus widths
   localparam int unsigned REG_W = 16;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 32;

   // Printed register offsets kept as word indices; byte address is four times these
   localparam logic [ADDR_W-1:0] IDX_PENDING = 20'h0_4600;
   localparam logic [ADDR_W-1:0] IDX_MISS = 20'h0_4602;
   localparam logic [ADDR_W-1:0] IDX_SWTRIG = 20'h0_4638;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 20'h0_4640;
   localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 20'h0_4642;

   // Reset values
   localparam logic [REG_W-1:0] RST_FLAGS = 16'h0000;
   localparam logic [REG_W-1:0] RST_SWTRIG = 16'h0000;
   localparam logic [1:0] RST_IRQ = 2'h0;

   // Flag bit positions
   localparam int unsigned BIT_WATCHDOG = 15;
   localparam int unsigned BIT_FAULT = 14;
   localparam int unsigned BIT_MAC_RECEIVE = 10;
   localparam int unsigned BIT_MAC_TRANSMIT = 9;
   localparam int unsigned BIT_MAC_TIMER = 8;
   localparam int unsigned BIT_SECURITY = 7;
   localparam int unsigned BIT_SLEEP = 4;
   localparam int unsigned BIT_BASEBAND = 3;
   localparam int unsigned BIT_DEBUG_LINK = 2;
   localparam int unsigned BIT_SOFTWARE = 1;

   // Bits that exist at all (bit 0 is reserved and reads zero)
   localparam logic [REG_W-1:0] IMPL_MASK = 16'hFFFE;
   // System-source bits that application-mode writes may not touch
   localparam logic [REG_W-1:0] SYS_MASK = 16'hC79E;

   // Own interrupt status layout
   localparam int unsigned IRQ_BIT_PENDING = 0;
   localparam int unsigned IRQ_BIT_MISS = 1;
   localparam int unsigned IRQ_W = 2;

   // Word index to byte address shift
   localparam int unsigned IDX_SHIFT = 2;
endpackage

// ---- hw/efm_reset_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Asynchronous assert, synchronous release of the block reset
module efm_reset_sync (
   // Clock and raw reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Released copy
   output logic rst_sync_n
);
   logic stage1_reg;
   logic stage2_reg;

   // Two stages so the release never lands near a clock edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end else begin
         stage1_reg <= 1'b1;
         stage2_reg <= stage1_reg;
      end
   end

   assign rst_sync_n = stage2_reg;
endmodule
`default_nettype wire

// ---- hw/efm_flag_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
// Bank of sticky flags: set by pulses, cleared by write-one
module efm_flag_bank #(
   parameter int unsigned WIDTH = 16,
   parameter logic [WIDTH-1:0] IMPL = '1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Per-bit set and clear requests
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clear_bits,
   // Current flags
   output logic [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   // Set is applied after clear so a coincident event is never lost
   always_comb begin
      flags_next = (flags_reg & ~clear_bits) | set_bits;
      flags_next = flags_next & IMPL;
   end

   // Flag storage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= RESET_VAL;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags = flags_reg;
endmodule
`default_nettype wire

// ---- dv/efm_event_flags_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module efm_event_flags_props #(
   parameter int unsigned FLAG_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Bus side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // Events and flags
   input wire logic [FLAG_W-1:0] event_pulse,
   input wire logic [FLAG_W-1:0] event_enable,
   input wire logic app_mode,
   input wire logic [FLAG_W-1:0] pending_flags,
   input wire logic [FLAG_W-1:0] miss_flags,
   input wire logic software_event_pulse
);
   logic [FLAG_W-1:0] hit;
   logic [15:0] wd;
   logic wr_pend, wr_miss, wr_trig, quiet;
   // Repeats while pending, and write access edges per register
   assign hit = event_pulse & event_enable & pending_flags & 16'hFFFE;
   assign wd = pwdata[15:0];
   assign wr_pend = psel && penable && pwrite && paddr == 20'h1_1800;
   assign wr_miss = psel && penable && pwrite && paddr == 20'h1_1808;
   assign wr_trig = psel && penable && pwrite && paddr == 20'h1_18E0;
   // No set source active, so a clear is seen alone
   assign quiet = event_pulse == 16'h0000 && !software_event_pulse && pstrb == 4'hF;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   flags_reset_a: assert property ($rose(rst_n) |-> pending_flags == 16'h0000
      && miss_flags == 16'h0000) else $error("flags not clear at reset");
   bit_zero_a: assert property (!pending_flags[0] && !miss_flags[0])
      else $error("bit zero set");
   event_set_a: assert property (|event_pulse[15:1] |=>
      (pending_flags & $past(event_pulse) & 16'hFFFE) == ($past(event_pulse) & 16'hFFFE))
      else $error("event did not set pending");
   miss_set_a: assert property (|hit |=> (miss_flags & $past(hit)) == $past(hit))
      else $error("repeat did not set miss");
   app_pend_a: assert property (wr_pend && app_mode |=>
      ($past(pending_flags) & ~pending_flags & efm_pkg::SYS_MASK) == 16'h0000)
      else $error("app write cleared system pending bit");
   app_miss_a: assert property (wr_miss && app_mode |=>
      ($past(miss_flags) & ~miss_flags & efm_pkg::SYS_MASK) == 16'h0000)
      else $error("app write cleared system miss bit");
   clear_pend_a: assert property (wr_pend && !app_mode && quiet |=>
      (pending_flags & $past(wd)) == 16'h0000
      && (pending_flags & ~$past(wd)) == ($past(pending_flags) & ~$past(wd)))
      else $error("write-one clear wrong");
   set_wins_a: assert property (wr_pend && |(event_pulse & wd & 16'hFFFE) |=>
      |(pending_flags & $past(event_pulse) & 16'hFFFE)) else $error("clear beat event");
   trig_pulse_a: assert property (wr_trig |=> software_event_pulse ##1 pending_flags[1])
      else $error("trigger write gave no software event");
endmodule
bind efm_event_flags efm_event_flags_props #(.FLAG_W(FLAG_W)) u_props (.sys_clk, .rst_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .event_pulse, .event_enable,
   .app_mode, .pending_flags, .miss_flags, .software_event_pulse);
`default_nettype wire

// ---- dv/efm_event_source.sv ----
`timescale 1ns/10ps
`default_nettype none
// Model of the on-chip event sources
module efm_event_source (
   // Clock
   input wire logic sys_clk,
   // Strobes toward the flag block
   output logic [15:0] event_pulse
);
   initial event_pulse = 16'h0000;
   // single-cycle strobes
   // Dropped at the very next edge, so a held level never fakes a repeat
   task automatic fire(input logic [15:0] bits);
      @(posedge sys_clk);
      event_pulse <= bits;
      @(posedge sys_clk);
      event_pulse <= 16'h0000;
   endtask
endmodule
`default_nettype wire

// ---- dv/test_event_flag_miss_swtrigger.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_event_flag_miss_swtrigger;
   // Byte addresses, four times the word index
   localparam logic [19:0] A_PEND = 20'h1_1800;
   localparam logic [19:0] A_MISS = 20'h1_1808;
   localparam logic [19:0] A_TRIG = 20'h1_18E0;
   localparam logic [19:0] A_STAT = 20'h1_1900;
   localparam logic [19:0] A_MASK = 20'h1_1908;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, app_mode, irq, err;
   logic software_event_pulse;
   logic [19:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] event_pulse, event_enable, pending_flags, miss_flags;
   int n_errors, n_compared;
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   efm_event_source src (.sys_clk, .event_pulse);
   efm_event_flags dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .event_pulse, .event_enable, .app_mode,
      .pending_flags, .miss_flags, .software_event_pulse, .irq);
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // One bus transfer; request held until pready is seen
   task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      check(q, exp);
   endtask
   task automatic test_done;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_errors++;
      test_done;
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 20'h0_0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      event_enable = 16'hFFFF;
      app_mode = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(A_PEND, 32'h0000_0000);
      rd(A_MISS, 32'h0000_0000);
      rd(A_TRIG, 32'h0000_0000);
      // All sources fire, then fire again before acknowledge
      src.fire(16'hFFFF);
      rd(A_PEND, 32'h0000_FFFE);
      src.fire(16'hFFFF);
      rd(A_MISS, 32'h0000_FFFE);
      // Application mode reaches only application bits
      app_mode <= 1'b1;
      xfer(1'b1, A_PEND, 32'h0000_FFFF);
      rd(A_PEND, 32'h0000_C79E);
      xfer(1'b1, A_MISS, 32'h0000_FFFF);
      rd(A_MISS, 32'h0000_C79E);
      app_mode <= 1'b0;
      xfer(1'b1, A_PEND, 32'h0000_0F00);
      rd(A_PEND, 32'h0000_C09E);
      xfer(1'b1, A_PEND, 32'h0000_FFFF);
      xfer(1'b1, A_MISS, 32'h0000_FFFF);
      rd(A_PEND, 32'h0000_0000);
      // Event lands on the acknowledge edge
      src.fire(16'h0200);
      fork
         xfer(1'b1, A_PEND, 32'h0000_0200);
         begin
            @(posedge sys_clk);
            src.fire(16'h0200);
         end
      join
      rd(A_PEND, 32'h0000_0200);
      rd(A_MISS, 32'h0000_0200);
      xfer(1'b1, A_PEND, 32'h0000_FFFF);
      xfer(1'b1, A_MISS, 32'h0000_FFFF);
      // Software trigger from application mode
      app_mode <= 1'b1;
      xfer(1'b1, A_TRIG, 32'h0000_1234);
      rd(A_TRIG, 32'h0000_1234);
      rd(A_PEND, 32'h0000_0002);
      app_mode <= 1'b0;
      // Disabled source repeats without a miss
      event_enable <= 16'h0000;
      src.fire(16'h0008);
      src.fire(16'h0008);
      rd(A_MISS, 32'h0000_0000);
      // Interrupt raised, masked and cleared by a status read
      xfer(1'b0, A_STAT, 32'h0000_0000);
      xfer(1'b1, A_MASK, 32'h0000_0000);
      src.fire(16'h0020);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0000);
      xfer(1'b1, A_MASK, 32'h0000_0001);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0001);
      rd(A_STAT, 32'h0000_0001);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0000_0000);
      // Trigger write with no strobes still fires, stored value kept
      xfer(1'b1, A_PEND, 32'h0000_FFFF);
      pstrb <= 4'h0;
      xfer(1'b1, A_TRIG, 32'h0000_ABCD);
      @(negedge sys_clk);
      check({31'h0, software_event_pulse}, 32'h0000_0001);
      @(posedge sys_clk);
      pstrb <= 4'hF;
      rd(A_TRIG, 32'h0000_1234);
      rd(A_PEND, 32'h0000_0002);
      // Misaligned place reads zero with an error
      rd(20'h1_1802, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      test_done;
   end
endmodule
`default_nettype wire
